// File: verilog/dig_input_pkg.sv
/*
 * Constants for the digital input event unit: register map, field
 * layout, input types, reset values and timing.
 * Assumes a 32-bit APB bus and a 125 MHz system clock.
 */
`default_nettype none
package dig_input_pkg;
	// Input type codes
	typedef enum logic [1:0] {
		TYPE_DISABLED = 2'h0,
		TYPE_TRIGGER  = 2'h1,
		TYPE_PRECIP   = 2'h2,
		TYPE_AIRSPEED = 2'h3
	} input_type_t;

	// Register byte offsets
	localparam logic [7:0] CFG0_OFF     = 8'h00;
	localparam logic [7:0] CFG1_OFF     = 8'h04;
	localparam logic [7:0] SCALE0_OFF   = 8'h08;
	localparam logic [7:0] SCALE1_OFF   = 8'h0c;
	localparam logic [7:0] VALUE0_OFF   = 8'h10;
	localparam logic [7:0] VALUE1_OFF   = 8'h14;
	localparam logic [7:0] LOW_LIM_OFF  = 8'h18;
	localparam logic [7:0] HIGH_LIM_OFF = 8'h1c;
	localparam logic [7:0] DER_LIM_OFF  = 8'h20;
	localparam logic [7:0] STATUS_OFF   = 8'h24;
	localparam logic [7:0] ALARM_OFF    = 8'h28;

	// Config register fields
	localparam int TYPE_LSB   = 0;
	localparam int EDGE_BIT   = 2;
	localparam int BURST_LSB  = 8;
	localparam int BURST_W    = 8;

	// Status register fields
	localparam int ST_BUSY0   = 0;
	localparam int ST_BUSY1   = 1;
	localparam int ST_AWAKE   = 2;
	localparam int ST_HOUR0   = 3;
	localparam int ST_HOUR1   = 4;

	// Alarm register fields, write one to clear
	localparam int AL_LOW     = 0;
	localparam int AL_HIGH    = 1;
	localparam int AL_DER     = 2;

	// Reset values
	localparam logic [31:0] CFG_RESET   = 32'h0000_0100;
	localparam logic [31:0] SCALE_RESET = 32'h0000_0001;
	// Limits open wide after reset so no alarm trips before software sets them
	localparam logic [31:0] LOW_LIM_RESET  = 32'h8000_0000;
	localparam logic [31:0] HIGH_LIM_RESET = 32'h7fff_ffff;
	localparam logic [31:0] DER_LIM_RESET  = 32'h7fff_ffff;

	// Precipitation period
	localparam longint CLK_HZ        = 125000000;
	localparam longint HOUR_S        = 3600;
	localparam longint HOUR_CYCLES   = HOUR_S * CLK_HZ;
endpackage
`default_nettype wire

// File: verilog/digital_input_event_unit.sv
/*
 * Digital input event unit: two pulse inputs used as burst triggers or
 * scaled pulse counters, plus a channel alarm check on converted values.
 * Assumes inputs synchronous-safe via internal synchronisers, an APB
 * master, and a sequencer that accepts one acquisition request per pulse.
 */
`timescale 1ns/1ps
`default_nettype none
//
// Overview of operation
// - Each input has a type: disabled, burst trigger, precipitation counter or airspeed counter.
// - The two inputs are configured independently and may run different types together.
// - In trigger type the edge setting picks a rising or a falling transition as the event.
// - Edge and burst length only matter in trigger type and are ignored otherwise.
// - Each trigger edge taken while the input is idle issues burst_length consecutive acquisitions of all channels; edges during a burst are dropped.
// - Burst acquisitions ignore the periodic timer and are stored like normal readings.
// - Counter types multiply the pulse count by the scale factor; trigger type does not.
// - Counter types report only the raw scaled count with no aggregation.
// - While any input is enabled the device stays awake and never enters low consumption.
// - An alarm is raised when a value is below the low limit or above the high limit.
// - The derivative alarm fires when the current sample minus the previous exceeds its limit.
// - Alarm comparisons use the converted value, not the raw reading.
// - Precipitation type counts pulses over one hour and records the count at the end.
// - On the same edge as recording, the pulse counter clears so the next hour starts fresh.
module digital_input_event_unit
	import dig_input_pkg::*;
#(
	parameter longint HOUR_COUNT = HOUR_CYCLES, // Hour period in clocks
	parameter int     CNT_W      = 16           // Pulse counter width
) (
	input  wire logic        pclk,               // System clock
	input  wire logic        presetn,            // Async reset, low
	input  wire logic        psel,               // APB select
	input  wire logic        penable,            // APB enable
	input  wire logic        pwrite,             // APB direction
	input  wire logic [7:0]  paddr,              // APB byte address
	input  wire logic [31:0] pwdata,             // APB write data
	output logic      [31:0] prdata,             // APB read data
	output logic             pready,             // APB ready
	output logic             pslverr,            // APB error
	input  wire logic        first_pulse_input,  // Rear input one
	input  wire logic        second_pulse_input, // Rear input two
	input  wire logic        conv_valid,         // Converted sample strobe
	input  wire logic [31:0] conv_value,         // Converted sample, signed
	input  wire logic        acq_done,           // Sequencer finished one acquisition
	output logic             acq_request,        // Acquisition request pulse
	output logic             stay_awake,         // Inhibit low consumption
	output logic             alarm               // Any channel alarm
);
	////////////////////////////////////////////////////////////////////////
	// Elaboration-time refusal of sizes the logic cannot serve
	if (CNT_W < 1 || CNT_W > 32 || HOUR_COUNT < 2) begin : g_bad_param
		$error("digital_input_event_unit: bad parameters");
	end

	localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);
	localparam logic [63:0]      HOUR_MAX = 64'(HOUR_COUNT - 1);

	typedef enum logic [2:0] {
		B_IDLE = 3'b001,
		B_REQ  = 3'b010,
		B_WAIT = 3'b100
	} burst_state_t;

	logic [1:0]         pin;
	logic [1:0]         sync1_reg, sync2_reg, prev_reg;
	logic [31:0]        cfg_reg   [2];
	logic [31:0]        cfg_next  [2];
	logic [31:0]        scale_reg [2];
	logic [31:0]        scale_next[2];
	logic [31:0]        value_reg [2];
	logic [31:0]        value_next[2];
	logic [CNT_W-1:0]   cnt_reg   [2];
	logic [CNT_W-1:0]   cnt_next  [2];
	logic [1:0]         hour_flag_reg, hour_flag_next;
	burst_state_t       bst_reg   [2];
	burst_state_t       bst_next  [2];
	logic [BURST_W-1:0] left_reg  [2];
	logic [BURST_W-1:0] left_next [2];
	logic [1:0]         req_one;
	logic [1:0]         grant;
	logic [1:0]         event_edge;
	logic [1:0]         pulse_edge;
	logic [63:0]        hour_reg, hour_next;
	logic               hour_tick;
	logic               wr, rd;

	assign pin = {second_pulse_input, first_pulse_input};
	assign wr  = psel && penable && pwrite;
	assign rd  = psel && !penable && !pwrite;

	////////////////////////////////////////////////////////////////////////
	// Two-stage synchroniser; only stage two and its delayed copy are used
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg <= 2'h0;
			sync2_reg <= 2'h0;
			prev_reg  <= 2'h0;
		end else begin
			sync1_reg <= pin;
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg;
		end
	end

	// Hour divider, shared by both inputs
	always_comb begin
		hour_tick = (hour_reg == HOUR_MAX);
		hour_next = hour_tick ? 64'h0 : hour_reg + 64'h1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			hour_reg <= 64'h0;
		else
			hour_reg <= hour_next;
	end

	////////////////////////////////////////////////////////////////////////
	// Per-input logic: configuration, counter and burst sequencer
	for (genvar i = 0; i < 2; i++) begin : g_in
		input_type_t ty;
		logic        rise, fall;

		assign ty   = input_type_t'(cfg_reg[i][TYPE_LSB +: 2]);
		assign rise = sync2_reg[i] && !prev_reg[i];
		assign fall = !sync2_reg[i] && prev_reg[i];
		// Edge setting only honoured in trigger type
		assign event_edge[i] = (ty == TYPE_TRIGGER) &&
			(cfg_reg[i][EDGE_BIT] ? fall : rise);
		// Counters count rising pulses
		assign pulse_edge[i] = (ty == TYPE_PRECIP || ty == TYPE_AIRSPEED) && rise;

		always_comb begin
			cfg_next[i]   = cfg_reg[i];
			scale_next[i] = scale_reg[i];
			value_next[i] = value_reg[i];
			cnt_next[i]   = cnt_reg[i];
			bst_next[i]   = bst_reg[i];
			left_next[i]  = left_reg[i];
			if (wr && paddr == (i == 0 ? CFG0_OFF : CFG1_OFF))
				cfg_next[i] = pwdata;
			if (wr && paddr == (i == 0 ? SCALE0_OFF : SCALE1_OFF))
				scale_next[i] = pwdata;
			// Counting; precipitation resets on the hour, airspeed runs on
			if (ty == TYPE_PRECIP && hour_tick) begin
				// Scaled hourly total only, no averaging or peaks
				value_next[i] = 32'(cnt_reg[i] + (pulse_edge[i] ? CNT_ONE : '0))
					* scale_reg[i];
				cnt_next[i]   = '0;
			end else if (pulse_edge[i]) begin
				cnt_next[i]   = cnt_reg[i] + CNT_ONE;
				if (ty == TYPE_AIRSPEED)
					value_next[i] = 32'(cnt_reg[i] + CNT_ONE) * scale_reg[i];
			end
			// Burst sequencer; busy bursts drop new edges
			case (bst_reg[i])
				B_IDLE: begin
					if (event_edge[i] && cfg_reg[i][BURST_LSB +: BURST_W] != '0) begin
						left_next[i] = cfg_reg[i][BURST_LSB +: BURST_W];
						bst_next[i]  = B_REQ;
					end
				end
				B_REQ: begin
					if (grant[i])
						bst_next[i] = B_WAIT;
				end
				B_WAIT: begin
					if (acq_done) begin
						left_next[i] = left_reg[i] - BURST_W'(1);
						bst_next[i]  = (left_reg[i] == BURST_W'(1)) ? B_IDLE : B_REQ;
					end
				end
				default: bst_next[i] = B_IDLE;
			endcase
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				cfg_reg[i]   <= CFG_RESET;
				scale_reg[i] <= SCALE_RESET;
				value_reg[i] <= 32'h0;
				cnt_reg[i]   <= '0;
				bst_reg[i]   <= B_IDLE;
				left_reg[i]  <= '0;
			end else begin
				cfg_reg[i]   <= cfg_next[i];
				scale_reg[i] <= scale_next[i];
				value_reg[i] <= value_next[i];
				cnt_reg[i]   <= cnt_next[i];
				bst_reg[i]   <= bst_next[i];
				left_reg[i]  <= left_next[i];
			end
		end

		assign req_one[i] = (bst_reg[i] == B_REQ);
	end

	// One request at a time; input one wins a tie, two waits its turn
	assign grant[0] = req_one[0] && !acq_request &&
		bst_reg[1] != B_WAIT;
	assign grant[1] = req_one[1] && !req_one[0] && !acq_request &&
		bst_reg[0] != B_WAIT;

	////////////////////////////////////////////////////////////////////////
	// Alarm evaluation on converted samples
	logic [31:0] low_reg, high_reg, der_reg, last_reg;
	logic [31:0] low_next, high_next, der_next, last_next;
	logic        have_last_reg, have_last_next;
	logic [2:0]  alm_reg, alm_next, alm_set;
	logic [31:0] diff;

	always_comb begin
		low_next       = low_reg;
		high_next      = high_reg;
		der_next       = der_reg;
		last_next      = last_reg;
		have_last_next = have_last_reg;
		diff           = conv_value - last_reg;
		alm_set        = 3'h0;
		if (wr && paddr == LOW_LIM_OFF)
			low_next = pwdata;
		if (wr && paddr == HIGH_LIM_OFF)
			high_next = pwdata;
		if (wr && paddr == DER_LIM_OFF)
			der_next = pwdata;
		if (conv_valid) begin
			// Converted values only, raw counts never reach here
			alm_set[AL_LOW]  = $signed(conv_value) < $signed(low_reg);
			alm_set[AL_HIGH] = $signed(conv_value) > $signed(high_reg);
			alm_set[AL_DER]  = have_last_reg &&
				$signed(diff) > $signed(der_reg);
			last_next      = conv_value;
			have_last_next = 1'b1;
		end
		// Set beats a same-cycle write-one clear
		alm_next = alm_reg;
		if (wr && paddr == ALARM_OFF)
			alm_next = alm_reg & ~pwdata[2:0];
		alm_next = alm_next | alm_set;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_reg       <= LOW_LIM_RESET;
			high_reg      <= HIGH_LIM_RESET;
			der_reg       <= DER_LIM_RESET;
			last_reg      <= 32'h0;
			have_last_reg <= 1'b0;
			alm_reg       <= 3'h0;
		end else begin
			low_reg       <= low_next;
			high_reg      <= high_next;
			der_reg       <= der_next;
			last_reg      <= last_next;
			have_last_reg <= have_last_next;
			alm_reg       <= alm_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs, hour flags and APB read path, all registered
	logic [31:0] rdata_next;
	logic        err_next;
	logic        awake_next;

	always_comb begin
		hour_flag_next = hour_flag_reg;
		for (int k = 0; k < 2; k++) begin
			if (wr && paddr == STATUS_OFF && pwdata[ST_HOUR0 + k])
				hour_flag_next[k] = 1'b0;
			if (hour_tick && input_type_t'(cfg_reg[k][TYPE_LSB +: 2]) == TYPE_PRECIP)
				hour_flag_next[k] = 1'b1;
		end
		awake_next = (cfg_reg[0][TYPE_LSB +: 2] != 2'(TYPE_DISABLED)) ||
			(cfg_reg[1][TYPE_LSB +: 2] != 2'(TYPE_DISABLED));
		err_next   = 1'b0;
		rdata_next = 32'h0;
		case (paddr)
			CFG0_OFF:     rdata_next = cfg_reg[0];
			CFG1_OFF:     rdata_next = cfg_reg[1];
			SCALE0_OFF:   rdata_next = scale_reg[0];
			SCALE1_OFF:   rdata_next = scale_reg[1];
			VALUE0_OFF:   rdata_next = value_reg[0];
			VALUE1_OFF:   rdata_next = value_reg[1];
			LOW_LIM_OFF:  rdata_next = low_reg;
			HIGH_LIM_OFF: rdata_next = high_reg;
			DER_LIM_OFF:  rdata_next = der_reg;
			STATUS_OFF: begin
				rdata_next[ST_BUSY0] = bst_reg[0] != B_IDLE;
				rdata_next[ST_BUSY1] = bst_reg[1] != B_IDLE;
				rdata_next[ST_AWAKE] = stay_awake;
				rdata_next[ST_HOUR0] = hour_flag_reg[0];
				rdata_next[ST_HOUR1] = hour_flag_reg[1];
			end
			ALARM_OFF:    rdata_next = {29'h0, alm_reg};
			default:      err_next = 1'b1;
		endcase
	end

	// Zero-wait slave would need comb data; one setup cycle fetches it instead
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata        <= 32'h0;
			pready        <= 1'b0;
			pslverr       <= 1'b0;
			acq_request   <= 1'b0;
			stay_awake    <= 1'b0;
			alarm         <= 1'b0;
			hour_flag_reg <= 2'h0;
		end else begin
			if (rd)
				prdata <= rdata_next;
			pready        <= psel && !penable;
			pslverr       <= psel && !penable && err_next;
			acq_request   <= |grant;
			stay_awake    <= awake_next;
			alarm         <= |alm_next;
			hour_flag_reg <= hour_flag_next;
		end
	end
endmodule // digital_input_event_unit
`default_nettype wire

// File: sim/dig_input_monitor.sv
/* Port checker for the digital input unit.
   Assumes it is bound onto the design top, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module dig_input_monitor
	import dig_input_pkg::*;
(
	input wire logic       pclk,        // Clock
	input wire logic       presetn,     // Reset, low
	input wire logic       psel,        // Select
	input wire logic       penable,     // Enable
	input wire logic       pwrite,      // Direction
	input wire logic [7:0] paddr,       // Address
	input wire logic       pready,      // Ready
	input wire logic       pslverr,     // Error
	input wire logic       conv_valid,  // Sample strobe
	input wire logic       acq_done,    // Sequencer done
	input wire logic       acq_request, // Request pulse
	input wire logic       stay_awake,  // Awake level
	input wire logic       alarm        // Alarm level
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////
	// Bus setup phase
	sequence setup_s;
		psel && !penable;
	endsequence
	// Bus answer timing, refusals
	chk_apb_answer: assert property (setup_s |=> pready) else $error("no ready");
	chk_ready_access: assert property (pready |-> psel && penable) else $error("stray ready");
	chk_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
	chk_err_unmapped: assert property (setup_s and paddr > ALARM_OFF |=> pslverr)
		else $error("unmapped not refused");
	// Requests: one cycle each, one outstanding, only when awake
	chk_req_pulse: assert property (acq_request |=> !acq_request) else $error("long request");
	chk_req_awake: assert property (acq_request |-> stay_awake) else $error("asleep");
	chk_one_outstanding: assert property (acq_request |=> !acq_request until acq_done)
		else $error("request before done");
	// Alarm rises only from a sample, falls only from a clear
	// Alarm output registers the same edge as the sticky bits, so one cycle back
	chk_alarm_cause: assert property ($rose(alarm) |-> $past(conv_valid))
		else $error("alarm without sample");
	chk_alarm_clear: assert property ($fell(alarm) |->
		$past(psel && penable && pwrite) && $past(paddr) == ALARM_OFF)
		else $error("alarm dropped alone");
endmodule // dig_input_monitor
bind digital_input_event_unit dig_input_monitor mon (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pready(pready), .pslverr(pslverr), .conv_valid(conv_valid),
	.acq_done(acq_done), .acq_request(acq_request), .stay_awake(stay_awake), .alarm(alarm));
`default_nettype wire

// File: sim/pulse_source.sv
/* Pulse source for the two rear inputs: trigger or sensor.
   Assumes the bench calls flip from one process at a time. */
`timescale 1ns/1ps
`default_nettype none
module pulse_source (
	input  wire logic       pclk,  // Clock
	output logic      [1:0] lines = 2'h0  // Input levels, idle low as with no voltage
);
	////////////////////////////////////////////////
	// Toggle one line after an edge, then hold it steady
	task automatic flip(input int ch, input int hold);
		@(posedge pclk);
		lines[ch] <= ~lines[ch];
		repeat (hold) @(posedge pclk);
	endtask
endmodule // pulse_source
`default_nettype wire

// File: sim/tb.sv
/* Bench: APB master, sequencer model and pulse source.
   Assumes the hour is shortened to 100 clocks. */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import dig_input_pkg::*;
	logic        pclk, pready, pslverr, acq_request, stay_awake, alarm, er;
	logic        presetn = 0, psel = 0, penable = 0, pwrite = 0, conv_valid = 0, acq_done = 0;
	logic [7:0]  paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, conv_value = 32'h0, prdata, rd, want_al;
	logic [1:0]  lines;
	int          err_total = 0, checks_done = 0, req_seen = 0, wait_left = 0;
	int          base, k, s, b, v, prev;
	logic [31:0] rst_val [11] = '{CFG_RESET, CFG_RESET, SCALE_RESET, SCALE_RESET, 32'h0,
		32'h0, LOW_LIM_RESET, HIGH_LIM_RESET, DER_LIM_RESET, 32'h0, 32'h0};
	digital_input_event_unit #(.HOUR_COUNT(100)) dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .first_pulse_input(lines[0]),
		.second_pulse_input(lines[1]), .conv_valid(conv_valid), .conv_value(conv_value),
		.acq_done(acq_done), .acq_request(acq_request), .stay_awake(stay_awake),
		.alarm(alarm));
	pulse_source src (.pclk(pclk), .lines(lines));
	// 125 MHz clock
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	// Sequencer: counts requests, answers after a random wait
	always @(posedge pclk) begin
		acq_done <= 1'b0;
		if (acq_request === 1'b1) begin
			req_seen++;
			wait_left = 1 + int'($urandom % 4);
		end else if (wait_left > 0) begin
			wait_left--;
			acq_done <= (wait_left == 0);
		end
	end
	////////////////////////////////////////////////
	task automatic check_word(input logic [31:0] got, input logic [31:0] want);
		checks_done++;
		if (got !== want) begin
			err_total++;
			$display("mismatch at %0t: got %h want %h", $time, got, want);
		end
	endtask
	task automatic summarize;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// One transfer; request held until ready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge pclk);
		if (pready !== 1'b1) begin
			err_total++;
			summarize();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] want);
		apb(1'b0, a, 32'h0);
		check_word(rd, want);
	endtask
	// Poll status until the masked bits match, bounded
	task automatic wait_status(input logic [31:0] mask, input logic [31:0] want);
		int n;
		for (n = 0; n < 300; n++) begin
			apb(1'b0, STATUS_OFF, 32'h0);
			if ((rd & mask) === want) break;
		end
		if (n == 300) begin
			err_total++;
			summarize();
		end
	endtask
	////////////////////////////////////////////////
	initial begin
		void'($urandom(32'hb11ff56d));
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values, then an unmapped place
		for (int i = 0; i < 11; i++) rdchk(8'(i * 4), rst_val[i]);
		apb(1'b0, 8'h40, 32'h0);
		check_word({31'h0, er}, 32'h1);
		check_word({31'h0, stay_awake}, 32'h0);
		// Rising trigger, random burst; two or more keeps the second edge mid-burst
		b = 2 + int'($urandom % 3);
		apb(1'b1, CFG0_OFF, 32'(b << 8 | 1));
		repeat (2) @(posedge pclk);
		check_word({31'h0, stay_awake}, 32'h1);
		base = req_seen;
		repeat (4) src.flip(0, 2);
		wait_status(32'h3, 32'h0);
		repeat (20) @(posedge pclk);
		check_word(32'(req_seen - base), 32'(b));
		// Falling select on the second input, first still armed
		apb(1'b1, CFG1_OFF, 32'h0000_0205);
		base = req_seen;
		src.flip(1, 10);
		check_word(32'(req_seen - base), 32'h0);
		src.flip(1, 2);
		wait_status(32'h3, 32'h0);
		repeat (10) @(posedge pclk);
		check_word(32'(req_seen - base), 32'h2);
		// Airspeed with edge and burst fields set but unused
		s = 1 + int'($urandom % 255);
		k = 1 + int'($urandom % 5);
		apb(1'b1, CFG0_OFF, 32'h0000_0507);
		apb(1'b1, SCALE0_OFF, 32'(s));
		base = req_seen;
		repeat (2 * k) src.flip(0, 2);
		repeat (4) @(posedge pclk);
		check_word(32'(req_seen - base), 32'h0);
		rdchk(VALUE0_OFF, 32'(k * s));
		// Precipitation hour with pulses, then an empty hour
		apb(1'b1, CFG1_OFF, 32'h0000_0002);
		apb(1'b1, SCALE1_OFF, 32'(s));
		wait_status(32'h10, 32'h10);
		apb(1'b1, STATUS_OFF, 32'h10);
		repeat (2 * k) src.flip(1, 2);
		wait_status(32'h10, 32'h10);
		rdchk(VALUE1_OFF, 32'(k * s));
		apb(1'b1, STATUS_OFF, 32'h10);
		wait_status(32'h10, 32'h10);
		rdchk(VALUE1_OFF, 32'h0);
		apb(1'b1, CFG0_OFF, 32'h0);
		apb(1'b1, CFG1_OFF, 32'h0);
		repeat (2) @(posedge pclk);
		check_word({31'h0, stay_awake}, 32'h0);
		// Random converted samples against limits and slope
		apb(1'b1, LOW_LIM_OFF, -32'sd20);
		apb(1'b1, HIGH_LIM_OFF, 32'd100);
		apb(1'b1, DER_LIM_OFF, 32'd30);
		for (int i = 0; i < 12; i++) begin
			v = int'($urandom % 200) - 60;
			@(posedge pclk);
			conv_valid <= 1'b1;
			conv_value <= 32'(v);
			@(posedge pclk);
			conv_valid <= 1'b0;
			want_al = {29'h0, i > 0 && v - prev > 30, v > 100, v < -20};
			prev = v;
			repeat (3) @(posedge pclk);
			check_word({31'h0, alarm}, {31'h0, |want_al});
			rdchk(ALARM_OFF, want_al);
			apb(1'b1, ALARM_OFF, 32'h7);
		end
		// Mid-run reset returns every register to its reset value
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 11; i++) rdchk(8'(i * 4), rst_val[i]);
		check_word({31'h0, stay_awake}, 32'h0);
		summarize();
	end
endmodule // tb
`default_nettype wire
